// ---- core/misc_instruction_control.sv ----
// Control of miscellaneous instructions: call gate, prefetch, barriers, counter, flag
//
// Functional notes
// (RL1) Hold library call until earlier instructions safe
// (RL2) Exception at call reports call's address
// (RL3) Library call traps into library routine
// (RL4) Prefetch selects aligned 512-byte block
// (RL5) Prefetch may be dropped; order free
// (RL6) Prefetch never faults; faulting ones dropped
// (RL7) Translation miss taken, then prefetch continues; code reports the miss and drops the prefetch
// (RL8) Modify variant requests write ownership
// (RL9) Barrier holds later memory ops until drained
// (RL10) Unordered completion allowed without barrier
// (RL11) Barrier only serialises, never hastens
// (RL12) Counter read returns 64-bit value
// (RL13) Low count wraps after all ones
// (RL14) Divider keeps wrap period long enough
// (RL15) Upper half holds per-process offset
// (RL16) Counter private to this processor
// (RL17) Trap fence stalls until no arithmetic trap
// (RL18) Flag copied out, then cleared or set
// (RL19) Flag cleared by exception return call
// (RL20) Flag unchanged by loads, stores, branches
// (RL21) Physical space split into four regions
// (RL22) Divider is build-time constant, exact
`timescale 1ns/1ps
module misc_instruction_control #(
  parameter int unsigned CYCLE_DIV = mic_pkg::CYCLE_DIV_DEFAULT,
  parameter int unsigned PA_W      = mic_pkg::PA_W
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  // Instruction issue
  input  wire logic                       instValid,
  input  wire mic_pkg::mic_op_t           instOp,
  input  wire logic [63:0]                instPc,
  input  wire logic [63:0]                baseRegister,
  input  wire logic                       exceptionReturnCall,
  output      logic                       instReady,
  // Pipeline status
  input  wire logic                       priorExceptionPossible,
  input  wire logic                       priorArithTrapPossible,
  input  wire logic                       priorMemPending,
  input  wire logic                       callException,
  // Per-process offset for the counter's upper half
  input  wire logic [31:0]                processOffset,
  // Result write-back
  output      logic                       destWrite,
  output      logic [63:0]                destRegister,
  // Library call trap
  output      logic                       palTrap,
  output      logic                       callExcept,
  output      logic [63:0]                continuationPc,
  // Memory ordering
  output      logic                       memIssueHold,
  // Translation and prefetch
  input  wire logic                       xlateHit,
  input  wire logic [PA_W-1:0]            xlatePa,
  input  wire logic                       loadWouldFault,
  input  wire logic                       storeWouldFault,
  output      logic                       xlateMissTrap,
  output      logic                       prefetchValid,
  input  wire logic                       prefetchReady,
  output      logic [PA_W-1:0]            prefetchAddr,
  output      logic                       prefetchOwn,
  output      logic [1:0]                 prefetchRegion
);
  localparam int unsigned OFS   = mic_pkg::BLOCK_OFS_W;
  localparam int unsigned RGN_W = mic_pkg::REGION_W;
  localparam int unsigned OP_W  = $bits(mic_pkg::mic_op_t);
  localparam int unsigned N_OPS = 1 << OP_W;

  // Counter link and drain state
  mic_count_if         cnt ();
  mic_pkg::mic_state_t state;
  mic_pkg::mic_state_t next_state;
  logic                needsDrain;
  logic                drainDone;
  logic                drainWait;
  logic                take;

  // Operation decode
  logic [N_OPS-1:0]    opHot;
  logic                isPal;
  logic                isFetchPlain;
  logic                isFetchModify;
  logic                isFetch;
  logic                isBarrier;
  logic                isRdCount;
  logic                isTrapFence;
  logic                isRdClear;
  logic                isRdSet;

  // Interrupted-sequence flag and prefetch staging
  logic                intrFlag;
  logic                pfBusy;
  logic                pfMiss;
  logic                pfFault;
  logic                pfLaunch;
  logic                pfRetire;
  logic                pfOwn;
  logic [PA_W-1:0]     pfBlock;
  logic [RGN_W-1:0]    pfRegion;

  // Parameters the logic cannot serve
  if (PA_W < OFS + RGN_W) begin : g_pa_small
    $error("PA_W too small");
  end
  if (PA_W > mic_pkg::VA_W) begin : g_pa_large
    $error("PA_W wider than the virtual address");
  end
  if ((1 << RGN_W) != 4) begin : g_regions
    $error("Physical space must split into four regions");
  end
  if (CYCLE_DIV < mic_pkg::CYCLE_DIV_MIN || CYCLE_DIV > mic_pkg::CYCLE_DIV_MAX) begin : g_div
    $error("CYCLE_DIV out of range");
  end

  // (RL16) private counter instance
  mic_cycle_counter #(
    .CYCLE_DIV (CYCLE_DIV)
  ) u_counter (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .cnt      (cnt)
  );

  // One compare per operation code
  for (genvar i = 0; i < N_OPS; i++) begin : g_op_decode
    assign opHot[i] = (instOp == OP_W'(i));
  end

  assign isPal         = opHot[mic_pkg::MIC_OP_PAL];
  assign isFetchPlain  = opHot[mic_pkg::MIC_OP_FETCH];
  assign isFetchModify = opHot[mic_pkg::MIC_OP_FETCH_M];
  assign isBarrier     = opHot[mic_pkg::MIC_OP_BARRIER];
  assign isRdCount     = opHot[mic_pkg::MIC_OP_RDCOUNT];
  assign isTrapFence   = opHot[mic_pkg::MIC_OP_TRAPFNC];
  assign isRdClear     = opHot[mic_pkg::MIC_OP_RDCLR];
  assign isRdSet       = opHot[mic_pkg::MIC_OP_RDSET];
  assign isFetch       = isFetchPlain || isFetchModify;

  // Ops that wait for earlier instructions to be safe
  always_comb begin
    needsDrain = 1'b0;
    drainDone  = 1'b1;
    case (instOp)
      // (RL1) exception drain
      mic_pkg::MIC_OP_PAL: begin
        needsDrain = 1'b1;
        drainDone  = !priorExceptionPossible;
      end
      // (RL17) arithmetic drain
      mic_pkg::MIC_OP_TRAPFNC: begin
        needsDrain = 1'b1;
        drainDone  = !priorArithTrapPossible;
      end
      // (RL9) memory drain
      mic_pkg::MIC_OP_BARRIER: begin
        needsDrain = 1'b1;
        drainDone  = !priorMemPending;
      end
      default: begin
        needsDrain = 1'b0;
        drainDone  = 1'b1;
      end
    endcase
  end

  // (RL11) waits only, issues nothing to speed memory
  always_comb begin
    next_state = state;
    case (state)
      mic_pkg::MIC_ST_IDLE: begin
        if (instValid && needsDrain && !drainDone)
          next_state = mic_pkg::MIC_ST_DRAIN;
      end
      mic_pkg::MIC_ST_DRAIN: begin
        if (drainDone)
          next_state = mic_pkg::MIC_ST_IDLE;
      end
      default: next_state = mic_pkg::MIC_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= mic_pkg::MIC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Issue gating
  // (RL1) (RL17) issue held until drained
  assign instReady = drainDone && !(isFetch && pfBusy);
  assign take      = instValid && instReady;
  assign drainWait = (state == mic_pkg::MIC_ST_DRAIN);
  // (RL9) (RL10) later memory ops held only around a barrier
  assign memIssueHold = instValid && isBarrier && (priorMemPending || drainWait);

  // Library call outcome
  // (RL3) trap into the library routine
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      palTrap <= 1'b0;
    end else begin
      palTrap <= take && isPal && !callException;
    end
  end

  // (RL2) exception reported at the call
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      callExcept <= 1'b0;
    end else begin
      callExcept <= take && isPal && callException;
    end
  end

  // (RL2) continuation points at the call itself
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      continuationPc <= 64'h0;
    end else if (take && isPal) begin
      continuationPc <= instPc;
    end
  end

  // Destination results
  // (RL12) (RL18) one-cycle write strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      destWrite <= 1'b0;
    end else begin
      destWrite <= take && (isRdCount || isRdClear || isRdSet);
    end
  end

  // (RL12) (RL15) (RL18) value held until the next write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      destRegister <= 64'h0;
    end else if (take) begin
      case (instOp)
        mic_pkg::MIC_OP_RDCOUNT: begin
          destRegister <= {processOffset, cnt.count};
        end
        mic_pkg::MIC_OP_RDCLR: begin
          destRegister <= {63'h0, intrFlag};
        end
        mic_pkg::MIC_OP_RDSET: begin
          destRegister <= {63'h0, intrFlag};
        end
        default: destRegister <= destRegister;
      endcase
    end
  end

  // Interrupted-sequence flag
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      intrFlag <= mic_pkg::FLAG_RESET;
    end else if (exceptionReturnCall) begin
      // (RL19) cleared by exception return
      intrFlag <= 1'b0;
    end else if (take && (instOp == mic_pkg::MIC_OP_RDCLR)) begin
      // (RL18) clear after read
      intrFlag <= 1'b0;
    end else if (take && (instOp == mic_pkg::MIC_OP_RDSET)) begin
      // (RL18) set after read
      intrFlag <= 1'b1;
    end
    // (RL20) no other op touches the flag
  end

  // Prefetch path; a stalled request blocks only later prefetches
  // (RL7) translation miss reported; the prefetch itself is dropped, not retried
  assign pfMiss   = take && isFetch && !xlateHit;
  // (RL6) faulting prefetches dropped silently
  assign pfFault  = loadWouldFault || (isFetchModify && storeWouldFault);
  assign pfLaunch = take && isFetch && xlateHit && !pfFault;
  // Accepted at the edge where ready is seen
  assign pfRetire = pfBusy && prefetchReady;

  // (RL4) aligned 512-byte block
  assign pfBlock  = {xlatePa[PA_W-1:OFS], OFS'(1'b0)};
  // (RL21) region from the two top address bits
  assign pfRegion = xlatePa[PA_W-1 -: RGN_W];
  // (RL8) ownership for modify intent
  assign pfOwn    = isFetchModify;

  // (RL7) one-cycle miss report
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      xlateMissTrap <= 1'b0;
    end else begin
      xlateMissTrap <= pfMiss;
    end
  end

  // Request stands until the memory side accepts it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pfBusy <= 1'b0;
    end else if (pfLaunch) begin
      pfBusy <= 1'b1;
    end else if (pfRetire) begin
      pfBusy <= 1'b0;
    end
  end

  // (RL4) request address
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prefetchAddr <= '0;
    end else if (pfLaunch) begin
      prefetchAddr <= pfBlock;
    end
  end

  // (RL21) request region
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prefetchRegion <= 2'h0;
    end else if (pfLaunch) begin
      prefetchRegion <= pfRegion;
    end
  end

  // (RL8) request ownership
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prefetchOwn <= 1'b0;
    end else if (pfLaunch) begin
      prefetchOwn <= pfOwn;
    end
  end

  // (RL5) memory side may drop or reorder within the block
  assign prefetchValid = pfBusy;
endmodule

// ---- inc/mic_pkg.sv ----
// Package for the miscellaneous instruction control block
package mic_pkg;
  localparam int unsigned CYCLE_DIV_DEFAULT = 1;
  localparam int unsigned CYCLE_DIV_MIN     = 1;
  localparam int unsigned CYCLE_DIV_MAX     = 16;
  localparam int unsigned COUNT_W           = 32;
  localparam int unsigned VA_W              = 64;
  localparam int unsigned PA_W              = 44;
  localparam int unsigned BLOCK_OFS_W       = 9;
  localparam int unsigned REGION_W          = 2;
  localparam logic [31:0] COUNT_RESET       = 32'h0000_0000;
  localparam logic [31:0] COUNT_ALL_ONES    = 32'hffff_ffff;
  localparam logic        FLAG_RESET        = 1'b0;

  typedef enum logic [2:0] {
    MIC_OP_PAL      = 3'h0,
    MIC_OP_FETCH    = 3'h1,
    MIC_OP_FETCH_M  = 3'h2,
    MIC_OP_BARRIER  = 3'h3,
    MIC_OP_RDCOUNT  = 3'h4,
    MIC_OP_TRAPFNC  = 3'h5,
    MIC_OP_RDCLR    = 3'h6,
    MIC_OP_RDSET    = 3'h7
  } mic_op_t;

  typedef enum logic [1:0] {
    MIC_ST_IDLE  = 2'b00,
    MIC_ST_DRAIN = 2'b01,
    MIC_ST_DONE  = 2'b10
  } mic_state_t;
endpackage

// ---- inc/mic_count_if.sv ----
// Interface between the control core and the cycle counter
`timescale 1ns/1ps
interface mic_count_if;
  logic [31:0] count;
  logic        tick;
  modport core (input count, input tick);
  modport counter (output count, output tick);
endinterface

// ---- core/mic_cycle_counter.sv ----
// Private per-processor cycle counter with prescaler
`timescale 1ns/1ps
module mic_cycle_counter #(
  parameter int unsigned CYCLE_DIV = mic_pkg::CYCLE_DIV_DEFAULT
) (
  // Clock and reset
  input  wire logic    core_clk,
  input  wire logic    reset_n,
  // Count to the core
  mic_count_if.counter cnt
);
  localparam int unsigned PRE_W = 4;

  logic [PRE_W-1:0] prescale;
  logic             tick;

  if (CYCLE_DIV < mic_pkg::CYCLE_DIV_MIN || CYCLE_DIV > mic_pkg::CYCLE_DIV_MAX) begin : g_div
    $error("CYCLE_DIV out of range");
  end

  // (RL22) exact divide-by-N
  assign tick = (prescale == PRE_W'(CYCLE_DIV - 1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= '0;
    end else if (tick) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // (RL12) (RL13) count and wrap
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt.count <= mic_pkg::COUNT_RESET;
    end else if (tick) begin
      cnt.count <= (cnt.count == mic_pkg::COUNT_ALL_ONES) ? mic_pkg::COUNT_RESET
                                                           : cnt.count + 32'h1;
    end
  end

  assign cnt.tick = tick;
endmodule

// ---- bench/mic_monitor.sv ----
// Checker of issue gating, trap reporting and prefetch outputs
`timescale 1ns/1ps
module mic_monitor #(
  parameter int unsigned PA_W = mic_pkg::PA_W
) (
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             reset_n,
  // Issue and status
  input wire logic             instValid,
  input wire mic_pkg::mic_op_t instOp,
  input wire logic [63:0]      instPc,
  input wire logic             instReady,
  input wire logic             priorExceptionPossible,
  input wire logic             priorArithTrapPossible,
  input wire logic             priorMemPending,
  input wire logic             callException,
  input wire logic [31:0]      processOffset,
  // Results
  input wire logic             destWrite,
  input wire logic [63:0]      destRegister,
  input wire logic             palTrap,
  input wire logic             callExcept,
  input wire logic [63:0]      continuationPc,
  // Prefetch
  input wire logic             prefetchValid,
  input wire logic             prefetchReady,
  input wire logic [PA_W-1:0]  prefetchAddr,
  input wire logic [1:0]       prefetchRegion
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire take  = instValid && instReady;
  wire isPal = instOp == mic_pkg::MIC_OP_PAL;
  a_call_gate: assert property (instValid && isPal && priorExceptionPossible |-> !instReady)
    else $error("library call issued while earlier op unsafe");
  a_fence_gate: assert property (instValid && instOp == mic_pkg::MIC_OP_TRAPFNC &&
    priorArithTrapPossible |-> !instReady) else $error("trap fence issued too early");
  a_barrier_gate: assert property (instValid && instOp == mic_pkg::MIC_OP_BARRIER &&
    priorMemPending |-> !instReady) else $error("barrier issued with memory pending");
  a_call_trap: assert property (take && isPal && !callException |=> palTrap)
    else $error("library call took no trap");
  a_cont_pc: assert property (take && isPal && callException |=>
    callExcept && continuationPc == $past(instPc)) else $error("wrong continuation address");
  a_count_offset: assert property (take && instOp == mic_pkg::MIC_OP_RDCOUNT |=>
    destWrite && destRegister[63:32] == $past(processOffset)) else $error("bad counter upper half");
  a_block_align: assert property (prefetchValid |-> prefetchAddr[8:0] == 9'h000)
    else $error("prefetch address not block aligned");
  a_region_bits: assert property (prefetchValid |-> prefetchRegion == prefetchAddr[PA_W-1 -: 2])
    else $error("prefetch region not top address bits");
  a_fetch_hold: assert property (prefetchValid && !prefetchReady |=>
    prefetchValid && $stable(prefetchAddr)) else $error("prefetch request dropped early");
endmodule
bind misc_instruction_control mic_monitor #(.PA_W(PA_W)) i_mic_monitor (.*);

// ---- bench/mic_mem_model.sv ----
// Memory hierarchy model that accepts prefetch requests after a random wait
`timescale 1ns/1ps
module mic_mem_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Prefetch handshake
  input  wire logic prefetchValid,
  output      logic prefetchReady,
  output      int   nTaken
);
  int waitCnt;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prefetchReady <= 1'b0;
      waitCnt <= 0;
      nTaken <= 0;
    end else if (prefetchValid && prefetchReady) begin
      prefetchReady <= 1'b0;
      nTaken <= nTaken + 1;
      waitCnt <= $urandom_range(3);
    end else if (prefetchValid && waitCnt == 0) begin
      prefetchReady <= 1'b1;
    end else if (prefetchValid) begin
      waitCnt <= waitCnt - 1;
    end
  end
endmodule

// ---- bench/misc_instruction_control_tb.sv ----
// Self-checking bench for the miscellaneous instruction control block
`timescale 1ns/1ps
module misc_instruction_control_tb;
  localparam int unsigned DIV  = 3;
  localparam int unsigned PA_W = mic_pkg::PA_W;
  logic core_clk, reset_n, instValid, exceptionReturnCall, callException, instReady;
  logic priorExceptionPossible, priorArithTrapPossible, priorMemPending, prefetchReady;
  logic xlateHit, loadWouldFault, storeWouldFault, destWrite, palTrap, callExcept;
  logic memIssueHold, xlateMissTrap, prefetchValid, prefetchOwn, drop;
  logic [1:0]      prefetchRegion;
  logic [31:0]     processOffset, lastCount;
  logic [63:0]     instPc, baseRegister, destRegister, continuationPc;
  logic [PA_W-1:0] xlatePa, prefetchAddr;
  mic_pkg::mic_op_t instOp, op;
  int n_mismatch, checks_done, nTaken, flag, i, r;
  misc_instruction_control #(.CYCLE_DIV(DIV), .PA_W(PA_W)) i_misc_instruction_control (.*);
  mic_mem_model i_mic_mem_model (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Offer one op, optionally held back by a status input, until taken
  task automatic issue(input mic_pkg::mic_op_t o, input logic [2:0] gate);
    int k;
    @(posedge core_clk);
    #1;
    {priorExceptionPossible, priorMemPending, priorArithTrapPossible} = gate;
    instOp = o;
    instPc = {$urandom, $urandom};
    instValid = 1'b1;
    for (k = 0; k < 60; k++) begin
      @(negedge core_clk);
      if (gate != 3'h0 && k < 3) begin
        if (k == 2) begin
          cmp("held", 1'b0, instReady);
          cmp("hold", gate == 3'h2, memIssueHold);
          @(posedge core_clk);
          #1 {priorExceptionPossible, priorMemPending, priorArithTrapPossible} = 3'h0;
        end
      end else if (instReady === 1'b1) begin
        break;
      end
    end
    if (k == 60) begin
      n_mismatch++;
      end_of_test();
    end
    @(posedge core_clk);
    #1 instValid = 1'b0;
  endtask
  initial begin
    {instValid, exceptionReturnCall, callException, xlateHit} = 4'h0;
    {loadWouldFault, storeWouldFault, priorExceptionPossible} = 3'h0;
    {priorMemPending, priorArithTrapPossible} = 2'h0;
    instOp = mic_pkg::MIC_OP_PAL;
    {instPc, baseRegister, processOffset, xlatePa} = '0;
    {n_mismatch, checks_done, flag} = '0;
    void'($urandom(93734));
    reset_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 reset_n = 1'b1;
    for (i = 0; i < 4; i++) begin
      callException = i[0];
      op = i < 2 ? mic_pkg::MIC_OP_PAL : (i == 2 ? mic_pkg::MIC_OP_BARRIER : mic_pkg::MIC_OP_TRAPFNC);
      issue(op, i < 2 ? 3'h4 : (i == 2 ? 3'h2 : 3'h1));
      if (i == 0) cmp("trap", 1'b1, palTrap);
      if (i == 1) cmp("except", 1'b1, callExcept);
      if (i == 1) cmp("contpc", instPc, continuationPc);
    end
    $display("Test gating done");
    for (i = 0; i < 4; i++) begin
      processOffset = $urandom;
      issue(mic_pkg::MIC_OP_RDCOUNT, 3'h0);
      cmp("write", 1'b1, destWrite);
      cmp("offset", processOffset, destRegister[63:32]);
      if (i > 0) cmp("count", lastCount + 32'h2, destRegister[31:0]);
      lastCount = destRegister[31:0];
      repeat (2 * DIV - 2) @(posedge core_clk);
      #1;
    end
    $display("Test counter done");
    for (i = 0; i < 14; i++) begin
      r = $urandom_range(2);
      if (r == 2) begin
        @(posedge core_clk);
        #1 exceptionReturnCall = 1'b1;
        @(posedge core_clk);
        #1 exceptionReturnCall = 1'b0;
        flag = 0;
      end else begin
        issue(r ? mic_pkg::MIC_OP_RDSET : mic_pkg::MIC_OP_RDCLR, 3'h0);
        cmp("flag", flag, destRegister);
        flag = r;
      end
    end
    $display("Test flag done");
    for (i = 0; i < 24; i++) begin
      r = $urandom_range(7);
      xlatePa = PA_W'({$urandom, $urandom});
      baseRegister = {$urandom, $urandom};
      xlateHit = r != 0;
      loadWouldFault = r == 1;
      storeWouldFault = r == 2 || r == 3;
      op = r[0] ? mic_pkg::MIC_OP_FETCH_M : mic_pkg::MIC_OP_FETCH;
      drop = !xlateHit || loadWouldFault || (storeWouldFault && r[0]);
      issue(op, 3'h0);
      cmp("miss", !xlateHit, xlateMissTrap);
      cmp("valid", !drop, prefetchValid);
      if (!drop) cmp("addr", {xlatePa[PA_W-1:9], 9'h000}, prefetchAddr);
      if (!drop) cmp("own", r[0], prefetchOwn);
      if (!drop) cmp("region", xlatePa[PA_W-1 -: 2], prefetchRegion);
    end
    $display("Test prefetch done");
    end_of_test();
  end
endmodule
